// >>> bench/pmx_far_model.sv
// far-side model: resolves each pad against the level the outside world drives
`timescale 1ns/1ps
module pmx_far_model (
    input  wire pmx_pkg::pmx_pad_s pb_pad_i,
    input  wire pmx_pkg::pmx_pad_s pc_pad_i,
    input  wire logic [7:0]        pb_ext_i,
    input  wire logic [7:0]        pc_ext_i,
    output logic      [7:0]        pb_pin_o,
    output logic      [7:0]        pc_pin_o
);
    import pmx_pkg::*;

    // driven bits show the pad, released bits show the outside level
    assign pb_pin_o = (pb_pad_i.oe & pb_pad_i.out) | (~pb_pad_i.oe & pb_ext_i);
    assign pc_pin_o = (pc_pad_i.oe & pc_pad_i.out) | (~pc_pad_i.oe & pc_ext_i);
endmodule // pmx_far_model

// >>> bench/pmx_port_mux_tb.sv
// self-checking bench of the port alternate-function mux
`timescale 1ns/1ps
module pmx_port_mux_tb;
    import pmx_pkg::*;
    localparam int         TMO      = 10000;
    localparam logic [7:0] IDX_T[8] = '{IDX_PORT_B_DATA, IDX_PORT_C_DATA, IDX_PORT_B_DIR,
        IDX_PORT_C_DIR, IDX_TIMER_CTRL, IDX_RELOAD_MODE, IDX_SERIAL_ROUTE, IDX_SERIAL_MODE};
    // master set-up of the upper five registers: clock pin out, all alternates on
    localparam logic [7:0] MST[5]   = '{8'h10, 8'h80, 8'h01, 8'h01, 8'h01};
    logic                  clk_i   = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  psel    = 1'b0;
    logic                  pen     = 1'b0;
    logic                  pwr     = 1'b0;
    logic [APB_ADDR_W-1:0] paddr   = '0;
    logic [31:0]           pwdata  = '0;
    logic [3:0]            pstrb   = '0;
    logic [7:0]            pb_ext  = '0;
    logic [7:0]            pc_ext  = '0;
    logic [7:0]            seed    = 8'h52;
    pmx_periph_s           periph  = '0;
    logic [31:0]           prdata, rd;
    logic                  pready, pslverr, err;
    logic [7:0]            pb_pin, pc_pin, pb_cfg, pc_cfg, wb, wc, v;
    logic [7:0]            rv[8];
    pmx_pad_s              pb_pad, pc_pad, e_pb, e_pc;
    pmx_route_s            route, e_rt;
    int                    n_mismatch  = 0;
    int                    checks_done = 0;
    int                    cyc         = 0;

    pmx_port_mux dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pb_pin_i(pb_pin),
        .pc_pin_i(pc_pin), .pb_pad_o(pb_pad), .pc_pad_o(pc_pad), .periph_i(periph),
        .route_o(route), .pb_in_cfg_o(pb_cfg), .pc_in_cfg_o(pc_cfg));
    pmx_far_model far (.pb_pad_i(pb_pad), .pc_pad_i(pc_pad), .pb_ext_i(pb_ext),
        .pc_ext_i(pc_ext), .pb_pin_o(pb_pin), .pc_pin_o(pc_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            n_mismatch++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic rnd(output logic [7:0] r);
        seed = lfsr(seed);
        r = seed;
    endtask
    // port read as software sees it: latch for outputs, pin for inputs
    function automatic logic [31:0] exp_port(input logic [7:0] data, input logic [7:0] dir,
                                             input logic [7:0] pin);
        return {24'h00_0000, (dir & data) | (~dir & pin)};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [7:0] d,
                       input logic [3:0] st);
        @(posedge clk_i);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        pstrb  <= st;
        @(posedge clk_i);
        pen <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    function automatic logic [APB_ADDR_W-1:0] adr(input logic [7:0] idx);
        return APB_ADDR_W'({idx, 2'b00});
    endfunction
    // expected pads, pin levels and routing from the register copy
    task automatic expect_all();
        e_pb = {rv[0], rv[2]};
        e_pc = {rv[1], rv[3]};
        if (rv[5][BIT_PWM_OUT_EN]) begin
            e_pb.oe[PIN_RELOAD_OUT]  = 1'b1;
            e_pb.out[PIN_RELOAD_OUT] = periph.pwm_out;
        end
        if (rv[4][BIT_TIMER_OUT_EN]) begin
            e_pc.oe[PIN_TIMER]  = 1'b1;
            e_pc.out[PIN_TIMER] = periph.timer_out;
        end
        if (rv[6][BIT_SOUT_ROUTE]) begin
            e_pc.oe[PIN_SOUT]  = 1'b1;
            e_pc.out[PIN_SOUT] = periph.sout;
        end
        if (rv[7][BIT_SCK_DRIVE] && rv[3][PIN_SCK]) e_pc.out[PIN_SCK] = periph.sck_out;
        e_pb.out = e_pb.out & e_pb.oe;
        e_pc.out = e_pc.out & e_pc.oe;
        wb = e_pb.out | (~e_pb.oe & pb_ext);
        wc = e_pc.out | (~e_pc.oe & pc_ext);
        e_rt.timer_in  = ~rv[4][BIT_TIMER_OUT_EN] & wc[PIN_TIMER];
        e_rt.reload_in = wb[PIN_RELOAD_IN];
        e_rt.sin       = ~rv[3][PIN_SIN] & wc[PIN_SIN];
        e_rt.sck_in    = ~rv[3][PIN_SCK] & ~rv[7][BIT_SCK_DRIVE] & wc[PIN_SCK];
    endtask
    // compare pads, routing and input selects, and read every register back
    task automatic verify();
        expect_all();
        chk(32'({pb_pad.out & pb_pad.oe, pb_pad.oe}), 32'(e_pb));
        chk(32'({pc_pad.out & pc_pad.oe, pc_pad.oe}), 32'(e_pc));
        chk(32'(route), 32'(e_rt));
        chk(32'({pb_cfg, pc_cfg}), {16'h0000, rv[0] & ~rv[2], rv[1] & ~rv[3]});
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, adr(IDX_T[k]), 8'h00, 4'h0);
            chk(rd & 32'h0000_00FF, rd);
            if (k == 0) chk(rd, exp_port(rv[0], rv[2], wb));
            else if (k == 1) chk(rd, exp_port(rv[1], rv[3], wc));
            else chk(rd, {24'h00_0000, rv[k]});
        end
    endtask
    task automatic finish_test();
        $display("TB: checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        for (int k = 0; k < 8; k++) rv[k] = RST_REG;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        verify();
        // refused accesses leave the route register cleared
        apb(1'b1, adr(IDX_SERIAL_ROUTE) | 12'h001, 8'h01, 4'h1);
        chk(32'(err), 32'd1);
        apb(1'b1, adr(IDX_SERIAL_ROUTE), 8'h01, 4'h0);
        apb(1'b0, adr(8'h10), 8'h00, 4'h0);
        chk({rd[30:0], err}, 32'd1);
        verify();
        for (int it = 0; it < 40; it++) begin
            for (int k = 0; k < 8; k++) rnd(rv[k]);
            if (it == 0) for (int k = 3; k < 8; k++) rv[k] = MST[k-3];
            if (it == 1) for (int k = 3; k < 8; k++) rv[k] = RST_REG;
            // whole bytes written each time
            for (int k = 0; k < 8; k++) apb(1'b1, adr(IDX_T[k]), rv[k], 4'h1);
            rnd(v);
            pb_ext <= v;
            rnd(v);
            pc_ext <= v;
            rnd(v);
            periph <= pmx_periph_s'(v[3:0]);
            repeat (6) @(posedge clk_i);
            verify();
        end
        // second reset in mid-run
        rst_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 8; k++) rv[k] = RST_REG;
        repeat (4) @(posedge clk_i);
        verify();
        finish_test();
    end
endmodule // pmx_port_mux_tb

// >>> design/pmx_pkg.sv
// package: register indices, field positions, reset values and carriers of the port mux
package pmx_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_B_DATA   = 8'hC1;
    localparam logic [7:0] IDX_PORT_C_DATA   = 8'hC2;
    localparam logic [7:0] IDX_PORT_B_DIR    = 8'hC5;
    localparam logic [7:0] IDX_PORT_C_DIR    = 8'hC6;
    localparam logic [7:0] IDX_TIMER_CTRL    = 8'hD4;
    localparam logic [7:0] IDX_RELOAD_MODE   = 8'hD5;
    localparam logic [7:0] IDX_SERIAL_ROUTE  = 8'hDD;
    localparam logic [7:0] IDX_SERIAL_MODE   = 8'hE2;

    // apb address width and the low bits that are the byte offset in a word
    localparam int         APB_ADDR_W        = 12;
    localparam int         WORD_SHIFT        = 2;

    // field positions inside the control registers
    localparam int         BIT_TIMER_OUT_EN  = 7;
    localparam int         BIT_PWM_OUT_EN    = 0;
    localparam int         BIT_SOUT_ROUTE    = 0;
    localparam int         BIT_SCK_DRIVE     = 0;

    // shared pin positions
    localparam int         PIN_TIMER         = 1;
    localparam int         PIN_SIN           = 2;
    localparam int         PIN_SOUT          = 3;
    localparam int         PIN_SCK           = 4;
    localparam int         PIN_RELOAD_IN     = 6;
    localparam int         PIN_RELOAD_OUT    = 7;

    // values after reset
    localparam logic [7:0] RST_REG           = 8'h00;
    localparam logic [7:0] RST_SERIAL_ROUTE  = 8'h00;

    // pad drive of one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pmx_pad_s;

    // signals the peripherals send towards the pins
    typedef struct packed {
        logic timer_out;
        logic pwm_out;
        logic sout;
        logic sck_out;
    } pmx_periph_s;

    // signals the pins send towards the peripherals
    typedef struct packed {
        logic timer_in;
        logic reload_in;
        logic sin;
        logic sck_in;
    } pmx_route_s;

endpackage

// >>> design/pmx_port_mux.sv
// port alternate-function mux with apb register file and pin routing
`timescale 1ns/1ps
module pmx_port_mux (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [pmx_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    input  wire logic [3:0]                    pstrb_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic [7:0]                    pb_pin_i,
    input  wire logic [7:0]                    pc_pin_i,
    output pmx_pkg::pmx_pad_s                  pb_pad_o,
    output pmx_pkg::pmx_pad_s                  pc_pad_o,
    input  wire pmx_pkg::pmx_periph_s          periph_i,
    output pmx_pkg::pmx_route_s                route_o,
    output logic      [7:0]                    pb_in_cfg_o,
    output logic      [7:0]                    pc_in_cfg_o
);
    import pmx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and synchronisers
    logic [7:0] port_b_data;
    logic [7:0] port_c_data;
    logic [7:0] port_b_direction_reg;
    logic [7:0] port_c_direction_reg;
    logic [7:0] timer_status_control_reg;
    logic [7:0] reload_timer_mode_control;
    logic [7:0] serial_output_route_control;
    logic [7:0] serial_mode;
    logic [7:0] pb_meta;
    logic [7:0] pb_sync;
    logic [7:0] pc_meta;
    logic [7:0] pc_sync;

    logic       timer_pin_output_enable;
    logic       reload_pwm_output_enable;
    logic       serial_out_select;
    logic       serial_clock_drive_select;
    logic [7:0] acc_idx;
    logic       acc_hit;
    logic       wr_en;
    logic [7:0] pb_read_now;
    logic [7:0] pc_read_now;

    // decoded control bits
    assign timer_pin_output_enable   = timer_status_control_reg[BIT_TIMER_OUT_EN];
    assign reload_pwm_output_enable  = reload_timer_mode_control[BIT_PWM_OUT_EN];
    assign serial_out_select         = serial_output_route_control[BIT_SOUT_ROUTE];
    assign serial_clock_drive_select = serial_mode[BIT_SCK_DRIVE];

    // word index of a byte address, upper address bits above the index are ignored
    function automatic logic [7:0] word_index(input logic [APB_ADDR_W-1:0] addr);
        word_index = addr[WORD_SHIFT+7:WORD_SHIFT];
    endfunction

    // true when an index names a register of this block
    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx == IDX_PORT_B_DATA) || (idx == IDX_PORT_C_DATA)
                  || (idx == IDX_PORT_B_DIR)  || (idx == IDX_PORT_C_DIR)
                  || (idx == IDX_TIMER_CTRL)  || (idx == IDX_RELOAD_MODE)
                  || (idx == IDX_SERIAL_ROUTE) || (idx == IDX_SERIAL_MODE);
    endfunction

    // port read: outputs give the latch, inputs give the pin
    function automatic logic [7:0] port_read(input logic [7:0] data,
                                             input logic [7:0] dir,
                                             input logic [7:0] pin);
        port_read = (data & dir) | (pin & ~dir);
    endfunction

    assign acc_idx = word_index(paddr_i);
    assign acc_hit = idx_mapped(acc_idx) && (paddr_i[WORD_SHIFT-1:0] == 2'b00);
    assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && acc_hit && pstrb_i[0];

    // live read value of each port, watched by the read-back checks
    assign pb_read_now = port_read(port_b_data, port_b_direction_reg, pb_sync);
    assign pc_read_now = port_read(port_c_data, port_c_direction_reg, pc_sync);

    ////////////////////////////////////////////////////////////////////////
    // two-flop pin synchronisers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pb_meta <= RST_REG;
            pb_sync <= RST_REG;
            pc_meta <= RST_REG;
            pc_sync <= RST_REG;
        end else begin
            pb_meta <= pb_pin_i;
            pb_sync <= pb_meta;
            pc_meta <= pc_pin_i;
            pc_sync <= pc_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, answer from flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !acc_hit;
            if (psel_i && penable_i && !pready_o) begin
                prdata_o <= 32'h0000_0000;
                if (acc_hit && !pwrite_i) begin
                    unique case (acc_idx)
                        IDX_PORT_B_DATA:  prdata_o[7:0] <= port_read(port_b_data,
                                              port_b_direction_reg, pb_sync);
                        IDX_PORT_C_DATA:  prdata_o[7:0] <= port_read(port_c_data,
                                              port_c_direction_reg, pc_sync);
                        IDX_PORT_B_DIR:   prdata_o[7:0] <= port_b_direction_reg;
                        IDX_PORT_C_DIR:   prdata_o[7:0] <= port_c_direction_reg;
                        IDX_TIMER_CTRL:   prdata_o[7:0] <= timer_status_control_reg;
                        IDX_RELOAD_MODE:  prdata_o[7:0] <= reload_timer_mode_control;
                        IDX_SERIAL_ROUTE: prdata_o[7:0] <= serial_output_route_control;
                        IDX_SERIAL_MODE:  prdata_o[7:0] <= serial_mode;
                        default:          prdata_o[7:0] <= RST_REG;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port data latches and directions
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            port_b_data          <= RST_REG;
            port_c_data          <= RST_REG;
            port_b_direction_reg <= RST_REG;
            port_c_direction_reg <= RST_REG;
        end else if (wr_en) begin
            if (acc_idx == IDX_PORT_B_DATA) port_b_data          <= pwdata_i[7:0];
            if (acc_idx == IDX_PORT_C_DATA) port_c_data          <= pwdata_i[7:0];
            if (acc_idx == IDX_PORT_B_DIR)  port_b_direction_reg <= pwdata_i[7:0];
            if (acc_idx == IDX_PORT_C_DIR)  port_c_direction_reg <= pwdata_i[7:0];
        end
    end

    // alternate-function select registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_status_control_reg    <= RST_REG;
            reload_timer_mode_control   <= RST_REG;
            serial_output_route_control <= RST_SERIAL_ROUTE;
            serial_mode                 <= RST_REG;
        end else if (wr_en) begin
            if (acc_idx == IDX_TIMER_CTRL)   timer_status_control_reg    <= pwdata_i[7:0];
            if (acc_idx == IDX_RELOAD_MODE)  reload_timer_mode_control   <= pwdata_i[7:0];
            if (acc_idx == IDX_SERIAL_ROUTE) serial_output_route_control <= pwdata_i[7:0];
            if (acc_idx == IDX_SERIAL_MODE)  serial_mode                 <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port b pad drive
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pb_pad_o <= '0;
        end else begin
            pb_pad_o.out <= port_b_data;
            pb_pad_o.oe  <= port_b_direction_reg;
            if (reload_pwm_output_enable) begin
                pb_pad_o.out[PIN_RELOAD_OUT] <= periph_i.pwm_out;
                pb_pad_o.oe[PIN_RELOAD_OUT]  <= 1'b1;
            end
        end
    end

    // port c pad drive, each alternate overrides only its own bit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_pad_o <= '0;
        end else begin
            pc_pad_o.out <= port_c_data;
            pc_pad_o.oe  <= port_c_direction_reg;
            if (timer_pin_output_enable) begin
                pc_pad_o.out[PIN_TIMER] <= periph_i.timer_out;
                pc_pad_o.oe[PIN_TIMER]  <= 1'b1;
            end
            if (serial_out_select) begin
                pc_pad_o.out[PIN_SOUT] <= periph_i.sout;
                pc_pad_o.oe[PIN_SOUT]  <= 1'b1;
            end
            if (serial_clock_drive_select && port_c_direction_reg[PIN_SCK]) begin
                pc_pad_o.out[PIN_SCK] <= periph_i.sck_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin to peripheral routing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            route_o <= '0;
        end else begin
            route_o.timer_in  <= !timer_pin_output_enable && pc_sync[PIN_TIMER];
            route_o.reload_in <= pb_sync[PIN_RELOAD_IN];
            route_o.sin       <= !port_c_direction_reg[PIN_SIN] && pc_sync[PIN_SIN];
            route_o.sck_in    <= !port_c_direction_reg[PIN_SCK]
                              && !serial_clock_drive_select && pc_sync[PIN_SCK];
        end
    end

    // input characteristic selects come from the latch of input bits
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pb_in_cfg_o <= RST_REG;
            pc_in_cfg_o <= RST_REG;
        end else begin
            pb_in_cfg_o <= port_b_data & ~port_b_direction_reg;
            pc_in_cfg_o <= port_c_data & ~port_c_direction_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_route_write;
        wr_en && (acc_idx == IDX_SERIAL_ROUTE) && pwdata_i[BIT_SOUT_ROUTE];
    endsequence

    sequence s_port_b_read;
        psel_i && penable_i && !pready_o && !pwrite_i && acc_hit
            && (acc_idx == IDX_PORT_B_DATA);
    endsequence

    sequence s_port_c_read;
        psel_i && penable_i && !pready_o && !pwrite_i && acc_hit
            && (acc_idx == IDX_PORT_C_DATA);
    endsequence

    property p_timer_std;
        !timer_pin_output_enable |=> pc_pad_o.oe[PIN_TIMER] == $past(port_c_direction_reg[PIN_TIMER])
            && route_o.timer_in == $past(pc_sync[PIN_TIMER]);
    endproperty
    a_timer_std: assert property (p_timer_std) else $error("timer pin not standard");

    property p_timer_forced;
        timer_pin_output_enable |=> pc_pad_o.oe[PIN_TIMER]
            && pc_pad_o.out[PIN_TIMER] == $past(periph_i.timer_out) && !route_o.timer_in;
    endproperty
    a_timer_forced: assert property (p_timer_forced) else $error("timer pin not forced");

    property p_pwm_std;
        !reload_pwm_output_enable |=> pb_pad_o.out[PIN_RELOAD_OUT]
            == $past(port_b_data[PIN_RELOAD_OUT]);
    endproperty
    a_pwm_std: assert property (p_pwm_std) else $error("reload out pin not standard");

    property p_pwm_drive;
        reload_pwm_output_enable |=> pb_pad_o.oe[PIN_RELOAD_OUT]
            && pb_pad_o.out[PIN_RELOAD_OUT] == $past(periph_i.pwm_out);
    endproperty
    a_pwm_drive: assert property (p_pwm_drive) else $error("pwm not on pin");

    property p_reload_in;
        1'b1 |=> route_o.reload_in == $past(pb_sync[PIN_RELOAD_IN]);
    endproperty
    a_reload_in: assert property (p_reload_in) else $error("reload input not routed");

    property p_sin_route;
        !port_c_direction_reg[PIN_SIN] |=> route_o.sin == $past(pc_sync[PIN_SIN]);
    endproperty
    a_sin_route: assert property (p_sin_route) else $error("data-in not routed");

    property p_sout;
        s_route_write ##1 1'b1 |=> pc_pad_o.oe[PIN_SOUT]
            && pc_pad_o.out[PIN_SOUT] == $past(periph_i.sout);
    endproperty
    a_sout: assert property (p_sout) else $error("data-out not selected");

    property p_sck_master;
        serial_clock_drive_select && port_c_direction_reg[PIN_SCK] |=>
            pc_pad_o.oe[PIN_SCK] && pc_pad_o.out[PIN_SCK] == $past(periph_i.sck_out)
            && !route_o.sck_in;
    endproperty
    a_sck_master: assert property (p_sck_master) else $error("clock not driven");

    property p_sck_slave;
        !serial_clock_drive_select && !port_c_direction_reg[PIN_SCK] |=>
            !pc_pad_o.oe[PIN_SCK] && route_o.sck_in == $past(pc_sync[PIN_SCK]);
    endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("slave clock not taken");

    property p_sck_std;
        !serial_clock_drive_select |=> pc_pad_o.out[PIN_SCK] == $past(port_c_data[PIN_SCK])
            && pc_pad_o.oe[PIN_SCK] == $past(port_c_direction_reg[PIN_SCK])
            && pc_pad_o.out[PIN_SIN] == $past(port_c_data[PIN_SIN])
            && pc_pad_o.oe[PIN_SIN] == $past(port_c_direction_reg[PIN_SIN]);
    endproperty
    a_sck_std: assert property (p_sck_std) else $error("data-in or clock pin not standard");

    property p_read_pin;
        s_port_c_read |=> prdata_o[7:0] == $past(pc_read_now) && pready_o;
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("port read wrong");

    property p_read_pb;
        s_port_b_read |=> prdata_o[7:0] == $past(pb_read_now) && pready_o;
    endproperty
    a_read_pb: assert property (p_read_pb) else $error("port b read wrong");

    property p_in_cfg_b;
        $stable(port_b_data) && $stable(port_b_direction_reg)
            |-> pb_in_cfg_o == (port_b_data & ~port_b_direction_reg);
    endproperty
    a_in_cfg_b: assert property (p_in_cfg_b) else $error("port b input select wrong");

    property p_in_cfg_c;
        $stable(port_c_data) && $stable(port_c_direction_reg)
            |-> pc_in_cfg_o == (port_c_data & ~port_c_direction_reg);
    endproperty
    a_in_cfg_c: assert property (p_in_cfg_c) else $error("port c input select wrong");

    property p_route_reset;
        $rose(rst_n_i) |-> serial_output_route_control == RST_SERIAL_ROUTE
            && !pc_pad_o.oe[PIN_SOUT];
    endproperty
    a_route_reset: assert property (p_route_reset) else $error("route not cleared");

endmodule // pmx_port_mux
